/* File: shared/eied_pkg.sv */
// Function
// - Select bit a set: falling only, else both
// - Select bit b set: falling only, else both
// - Pin b active edge wakes power-down
// - Pin c requests on falling edge only
// - Pin c falling edge wakes power-down
// - Pin d requests on falling edge only
// - Pin e requests on falling edge only
// - Pin e falling edge wakes power-down
// - Pin d falling edge wakes power-down
package eied_pkg;
   localparam int unsigned EIED_NUM_SRC = 5;
   localparam int unsigned EIED_SYNC_STAGES = 2;
   localparam logic [4:0] EIED_PEND_RESET = 5'h00;
   localparam logic [4:0] EIED_PIN_RESET = 5'h1F;
   // Pins a and b may be set to both edges; c, d, e are falling only
   localparam logic [4:0] EIED_SELECTABLE = 5'h03;
   localparam logic [4:0] EIED_WAKE_CAPABLE = 5'h1E;
   localparam int unsigned EIED_EDGE_SEL_A_BIT = 0;
   localparam int unsigned EIED_EDGE_SEL_B_BIT = 2;
endpackage : eied_pkg

/* File: src/eied_sync.sv */
`timescale 1ns/1ps
module eied_sync
   import eied_pkg::*;
#(
   parameter int unsigned WIDTH = EIED_NUM_SRC
) (
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   // Refused at elaboration: a zero-width synchroniser has nothing to carry
   if (WIDTH < 1) begin : g_width_check
      $error("eied_sync: WIDTH must be at least 1");
   end

   // First stage feeds only the second stage
   always_comb begin
      meta_d = async_in;
      sync_d = meta_q;
   end

   // Idle level is high so reset release sees no false falling edge
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         meta_q <= {WIDTH{1'b1}};
         sync_q <= {WIDTH{1'b1}};
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_out = sync_q;
endmodule : eied_sync

/* File: src/eied_top.sv */
`timescale 1ns/1ps
module eied_top
   import eied_pkg::*;
(
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic ext_irq_pin_a_in,
   input wire logic ext_irq_pin_b_in,
   input wire logic ext_irq_pin_c_in,
   input wire logic ext_irq_pin_d_in,
   input wire logic ext_irq_pin_e_in,
   input wire logic [7:0] timer_control_reg_in,
   input wire logic power_down_in,
   input wire logic [4:0] pend_clear_in,
   output logic [4:0] pend_out,
   output logic wake_out
);
   logic [4:0] pins_raw;
   logic [4:0] pins_sync;
   logic [4:0] prev_q;
   logic [4:0] prev_d;
   logic [4:0] pend_q;
   logic [4:0] pend_d;
   logic wake_q;
   logic wake_d;
   wire [4:0] fall;
   wire [4:0] rise;
   wire [4:0] qual;
   logic [4:0] both_edges;
   logic edge_select_a;
   logic edge_select_b;

   assign pins_raw = {ext_irq_pin_e_in, ext_irq_pin_d_in, ext_irq_pin_c_in, ext_irq_pin_b_in, ext_irq_pin_a_in};
   assign edge_select_a = timer_control_reg_in[EIED_EDGE_SEL_A_BIT];
   assign edge_select_b = timer_control_reg_in[EIED_EDGE_SEL_B_BIT];
   // Sources c, d and e have no select bit and stay falling only
   assign both_edges = EIED_SELECTABLE & {3'h0, ~edge_select_b, ~edge_select_a};

   ////////////////////////////////////////////////////////////////////////////
   // Ports are fixed at five sources and the synchroniser has two stages
   if (EIED_NUM_SRC != 5) begin : g_src_check
      $error("eied_top: five interrupt sources expected");
   end
   if (EIED_SYNC_STAGES != 2) begin : g_stage_check
      $error("eied_top: two synchroniser stages expected");
   end
   if (EIED_EDGE_SEL_A_BIT > 7 || EIED_EDGE_SEL_B_BIT > 7) begin : g_sel_check
      $error("eied_top: edge select bit outside the control register");
   end

   ////////////////////////////////////////////////////////////////////////////
   eied_sync #(
      .WIDTH(EIED_NUM_SRC)
   ) u_sync (
      .mclk_in(mclk_in),
      .resetn_in(resetn_in),
      .async_in(pins_raw),
      .sync_out(pins_sync)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Edge qualification per source
   for (genvar g = 0; g < EIED_NUM_SRC; g++) begin : g_src
      assign fall[g] = prev_q[g] & ~pins_sync[g];
      assign rise[g] = ~prev_q[g] & pins_sync[g];
      assign qual[g] = fall[g] | (rise[g] & both_edges[g]);
   end

   // Set beats clear so an edge in the clear cycle is kept
   always_comb begin
      prev_d = pins_sync;
      pend_d = (pend_q & ~pend_clear_in) | qual;
      // Wake held until power-down is left; pin a cannot wake
      wake_d = power_down_in & (wake_q | (|(qual & EIED_WAKE_CAPABLE)));
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         prev_q <= EIED_PIN_RESET;
         pend_q <= EIED_PEND_RESET;
         wake_q <= 1'b0;
      end else begin
         prev_q <= prev_d;
         pend_q <= pend_d;
         wake_q <= wake_d;
      end
   end

   assign pend_out = pend_q;
   assign wake_out = wake_q;

   ////////////////////////////////////////////////////////////////////////////
   AST_A_FALL: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      $fell(pins_sync[0]) |=> pend_q[0]) else $error("pin a falling edge lost");
   AST_A_RISE_SEL: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      ($rose(pins_sync[0]) && edge_select_a && !pend_q[0]) |=> !pend_q[0]) else $error("pin a rise not filtered");
   AST_A_RISE_BOTH: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      ($rose(pins_sync[0]) && !edge_select_a) |=> pend_q[0]) else $error("pin a rise lost");
   AST_B_RISE: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      ($rose(pins_sync[1]) && !pend_q[1]) |=> pend_q[1] == !edge_select_b) else $error("pin b select wrong");
   AST_C_RISE: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      ($rose(pins_sync[2]) && !pend_q[2]) |=> !pend_q[2]) else $error("pin c rise requested");
   AST_D_FALL: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      ($fell(pins_sync[3]) && !$rose(pins_sync[3])) |=> pend_q[3]) else $error("pin d fall lost");
   AST_E_RISE: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      ($rose(pins_sync[4]) && !pend_q[4]) |=> !pend_q[4]) else $error("pin e rise requested");
   AST_WAKE_C: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      ($fell(pins_sync[2]) && power_down_in) |=> wake_q) else $error("pin c no wake");
   AST_WAKE_E: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      ($fell(pins_sync[4]) && power_down_in) |=> wake_q) else $error("pin e no wake");
   AST_WAKE_D: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      ($fell(pins_sync[3]) && power_down_in) |=> wake_q) else $error("pin d no wake");
   AST_WAKE_B: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      ($fell(pins_sync[1]) && power_down_in) |=> wake_q) else $error("pin b no wake");
   AST_SET_WINS: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      ($fell(pins_sync[4]) && pend_clear_in[4]) |=> pend_q[4]) else $error("clear beat set");
   AST_NO_WAKE_RUN: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      !power_down_in |=> !wake_q) else $error("wake outside power-down");

   ////////////////////////////////////////////////////////////////////////////
   // Per-pin requests, pending hold and clear, wake cause
   AST_B_FALL: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      $fell(pins_sync[1]) |=> pend_q[1]
   ) else $error("pin b falling edge lost");
   AST_C_FALL: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      $fell(pins_sync[2]) |=> pend_q[2]
   ) else $error("pin c falling edge lost");
   AST_E_FALL: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      $fell(pins_sync[4]) |=> pend_q[4]
   ) else $error("pin e falling edge lost");
   AST_D_RISE: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      ($rose(pins_sync[3]) && !pend_q[3]) |=> !pend_q[3]
   ) else $error("pin d rise requested");
   AST_B_RISE_WAKE: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      ($rose(pins_sync[1]) && !edge_select_b && power_down_in) |=> wake_q
   ) else $error("pin b rise no wake");
   AST_B_SEL_NO_WAKE: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      ($rose(pins_sync[1]) && edge_select_b && !wake_q && $stable(pins_sync[4:2])) |=> !wake_q
   ) else $error("pin b filtered rise woke");
   AST_C_RISE_NO_WAKE: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      ($rose(pins_sync[2]) && !wake_q && $stable(pins_sync[1]) && $stable(pins_sync[4:3])) |=> !wake_q
   ) else $error("pin c rise woke");
   AST_E_RISE_NO_WAKE: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      ($rose(pins_sync[4]) && !wake_q && $stable(pins_sync[3:1])) |=> !wake_q
   ) else $error("pin e rise woke");
   AST_A_NO_WAKE: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      (!wake_q && $stable(pins_sync[4:1])) |=> !wake_q
   ) else $error("wake without edge on b to e");
   AST_WAKE_HOLD: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      (wake_q && power_down_in) |=> wake_q
   ) else $error("wake dropped in power-down");
   AST_WAKE_PEND: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      $rose(wake_q) |-> pend_q[4:1] != 4'h0
   ) else $error("wake without pending request");
   AST_HOLD_A: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      (pend_q[0] && !pend_clear_in[0]) |=> pend_q[0]
   ) else $error("pin a pending dropped");
   AST_HOLD_B: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      (pend_q[1] && !pend_clear_in[1]) |=> pend_q[1]
   ) else $error("pin b pending dropped");
   AST_HOLD_C: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      (pend_q[2] && !pend_clear_in[2]) |=> pend_q[2]
   ) else $error("pin c pending dropped");
   AST_HOLD_D: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      (pend_q[3] && !pend_clear_in[3]) |=> pend_q[3]
   ) else $error("pin d pending dropped");
   AST_HOLD_E: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      (pend_q[4] && !pend_clear_in[4]) |=> pend_q[4]
   ) else $error("pin e pending dropped");
   AST_CLEAR_A: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      (pend_clear_in[0] && $stable(pins_sync[0])) |=> !pend_q[0]
   ) else $error("pin a pending not cleared");
   AST_CLEAR_B: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      (pend_clear_in[1] && $stable(pins_sync[1])) |=> !pend_q[1]
   ) else $error("pin b pending not cleared");
   AST_CLEAR_C: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      (pend_clear_in[2] && $stable(pins_sync[2])) |=> !pend_q[2]
   ) else $error("pin c pending not cleared");
   AST_CLEAR_D: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      (pend_clear_in[3] && $stable(pins_sync[3])) |=> !pend_q[3]
   ) else $error("pin d pending not cleared");
   AST_CLEAR_E: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      (pend_clear_in[4] && $stable(pins_sync[4])) |=> !pend_q[4]
   ) else $error("pin e pending not cleared");
   AST_NO_SPURIOUS: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      (pend_q == 5'h00 && $stable(pins_sync)) |=> pend_q == 5'h00
   ) else $error("request without pin edge");
   AST_RESET_STATE: assert property (
      @(posedge mclk_in)
      !resetn_in |=> (pend_q == EIED_PEND_RESET && !wake_q)
   ) else $error("state not cleared by reset");
   AST_SYNC_DELAY: assert property (
      @(posedge mclk_in) disable iff (!resetn_in)
      ($past(resetn_in) && $past(resetn_in, 2)) |-> pins_sync == $past(pins_raw, 2)
   ) else $error("pin sample latency wrong");

   COV_A_BOTH: cover property (@(posedge mclk_in) disable iff (!resetn_in) $rose(pins_sync[0]) && !edge_select_a);
   COV_WAKE: cover property (@(posedge mclk_in) disable iff (!resetn_in) $rose(wake_q));
   COV_CLEAR: cover property (@(posedge mclk_in) disable iff (!resetn_in) pend_q[2] ##1 !pend_q[2]);
   COV_SET_WINS: cover property (@(posedge mclk_in) disable iff (!resetn_in) pend_clear_in[4] && $fell(pins_sync[4]));
   COV_B_WAKE: cover property (@(posedge mclk_in) disable iff (!resetn_in) $rose(pins_sync[1]) && power_down_in);
endmodule : eied_top

/* File: sim/eied_pin_drv.sv */
`timescale 1ns/1ps
module eied_pin_drv (
   input wire logic mclk_in,
   input wire logic [4:0] level_in,
   output logic [4:0] pins_out
);
   // External pins move one edge after request, never mid-cycle
   always @(posedge mclk_in) begin
      pins_out <= level_in;
   end
endmodule : eied_pin_drv

/* File: sim/test_external_interrupt_edge_detect.sv */
`timescale 1ns/1ps
module test_external_interrupt_edge_detect;
   logic mclk_in, resetn_in, pd, wake;
   logic [4:0] lvl, pins, clr, pend;
   logic [7:0] tcr;
   int errors, checks_done;
   eied_pin_drv i_pins (.mclk_in(mclk_in), .level_in(lvl), .pins_out(pins));
   eied_top i_dut (.mclk_in(mclk_in), .resetn_in(resetn_in), .ext_irq_pin_a_in(pins[0]),
      .ext_irq_pin_b_in(pins[1]), .ext_irq_pin_c_in(pins[2]), .ext_irq_pin_d_in(pins[3]),
      .ext_irq_pin_e_in(pins[4]), .timer_control_reg_in(tcr), .power_down_in(pd),
      .pend_clear_in(clr), .pend_out(pend), .wake_out(wake));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      mclk_in = 1'b0;
      forever #20 mclk_in = ~mclk_in;
   end
   task automatic chk(input logic [5:0] exp, input logic [5:0] got);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: exp %h got %h", $time, exp, got);
      end
   endtask : chk
   task automatic conclude;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : conclude
   ////////////////////////////////////////////////////////////////////////////////
   // One pin edge in power-down, then clear; fixed waits cover the 4-edge request-to-pending latency
   task automatic step(input int i, input logic lv, input logic sel);
      logic q;
      q = !lv || (i < 2 && !sel);
      @(posedge mclk_in);
      lvl <= lv ? (lvl | (5'h01 << i)) : (lvl & ~(5'h01 << i));
      tcr <= sel ? 8'h05 : 8'h00;
      pd <= 1'b1;
      repeat (6) @(posedge mclk_in);
      #1 chk({q && i > 0, 5'(q) << i}, {wake, pend});
      @(posedge mclk_in);
      pd <= 1'b0;
      clr <= 5'h1F;
      repeat (2) @(posedge mclk_in);
      clr <= 5'h00;
      #1 chk(6'h00, {wake, pend});
      $display("test pin %0d level %0d select %0d done", i, lv, sel);
   endtask : step
   // Clear and a new falling edge on one edge: the edge must survive
   task automatic set_wins;
      @(posedge mclk_in);
      pd <= 1'b0;
      lvl <= 5'h0F;
      repeat (3) @(posedge mclk_in);
      clr <= 5'h10;
      @(posedge mclk_in);
      clr <= 5'h00;
      #1 chk(6'h10, {wake, pend});
      @(posedge mclk_in);
      clr <= 5'h10;
      lvl <= 5'h1F;
      @(posedge mclk_in);
      clr <= 5'h00;
      #1 chk(6'h00, {wake, pend});
      repeat (5) @(posedge mclk_in);
      #1 chk(6'h00, {wake, pend});
      $display("test set wins done");
   endtask : set_wins
   // Reset mid-run with pin c low: pending clears, one edge follows release
   task automatic mid_reset;
      @(posedge mclk_in);
      lvl <= 5'h1B;
      repeat (6) @(posedge mclk_in);
      #1 chk(6'h04, {wake, pend});
      @(posedge mclk_in);
      resetn_in <= 1'b0;
      repeat (3) @(posedge mclk_in);
      #1 chk(6'h00, {wake, pend});
      @(posedge mclk_in);
      resetn_in <= 1'b1;
      repeat (4) @(posedge mclk_in);
      #1 chk(6'h04, {wake, pend});
      @(posedge mclk_in);
      lvl <= 5'h1F;
      clr <= 5'h04;
      @(posedge mclk_in);
      clr <= 5'h00;
      repeat (5) @(posedge mclk_in);
      #1 chk(6'h00, {wake, pend});
      $display("test mid reset done");
   endtask : mid_reset
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      resetn_in = 1'b0;
      lvl = 5'h1F;
      tcr = 8'h00;
      pd = 1'b0;
      clr = 5'h00;
      errors = 0;
      checks_done = 0;
      repeat (3) @(posedge mclk_in);
      resetn_in <= 1'b1;
      @(posedge mclk_in);
      #1 chk(6'h00, {wake, pend});
      for (int s = 0; s < 2; s++) begin
         for (int i = 0; i < 5; i++) begin
            step(i, 1'b0, s[0]);
            step(i, 1'b1, s[0]);
         end
      end
      set_wins();
      mid_reset();
      conclude();
   end
endmodule : test_external_interrupt_edge_detect
